// ### ppc_crossbar.sv
// Priority pin crossbar: pin assignment, pin drivers, event capture
`timescale 1ns/100ps
module ppc_crossbar #(
   parameter int PCA_CHANNELS = 6
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Crossbar configuration
   input wire logic crossbar_enable_bit,
   input wire ppc_pkg::ppc_fsel_s fsel,
   input wire logic [1:0] slave_select_mode_bits,
   input wire logic [ppc_pkg::PORT0_W-1:0] port0_skip_vector,
   input wire logic [ppc_pkg::PORT1_W-1:0] port1_skip_vector,
   input wire ppc_pkg::ppc_fixed_s fixed_sel,
   // Pin configuration
   input wire logic [ppc_pkg::NUM_PINS-1:0] pin_digital,
   input wire logic [ppc_pkg::NUM_PINS-1:0] output_mode_select,
   input wire logic [ppc_pkg::NUM_PINS-1:0] gpio_latch,
   input wire logic p27_latch,
   input wire logic p27_push_pull,
   // Event capture configuration
   input wire ppc_pkg::ppc_evt_cfg_s evt_cfg,
   input wire logic [ppc_pkg::NUM_PINS-1:0] match_mask,
   input wire logic [ppc_pkg::NUM_PINS-1:0] match_value,
   // Peripheral side
   input wire logic [ppc_pkg::NUM_SLOTS-1:0] periph_out,
   input wire logic [ppc_pkg::NUM_SLOTS-1:0] periph_drive,
   output logic [ppc_pkg::NUM_SLOTS-1:0] periph_in,
   // Port pins
   input wire logic [ppc_pkg::NUM_PINS-1:0] pin_in,
   output logic [ppc_pkg::NUM_PINS-1:0] pin_out,
   output logic [ppc_pkg::NUM_PINS-1:0] pin_oe,
   output logic [ppc_pkg::NUM_PINS-1:0] pin_read,
   input wire logic p27_in,
   output logic p27_out,
   output logic p27_oe,
   output logic p27_read,
   // Analog bypass switches
   output ppc_pkg::ppc_fixed_s analog_sw,
   // Events and status
   output logic ext_irq0_evt,
   output logic ext_irq1_evt,
   output logic port_match,
   output logic match_wake,
   output logic [ppc_pkg::NUM_PINS-1:0] pin_assigned
);
   localparam int NP = ppc_pkg::NUM_PINS;
   localparam int NS = ppc_pkg::NUM_SLOTS;
   localparam int SW = ppc_pkg::SLOT_W;

   if (PCA_CHANNELS < 0 || PCA_CHANNELS > ppc_pkg::PCA_MAX) begin : g_chk
      $error("PCA_CHANNELS out of range");
   end

   // skip bit n is pin n
   wire [NP-1:0] skip_vec = {port1_skip_vector, port0_skip_vector};
   wire nss_4wire = slave_select_mode_bits != ppc_pkg::NSS_MODE_3WIRE;
   wire [ppc_pkg::NUM_SLOTS-1:0] slot_en;

   assign slot_en[ppc_pkg::SLOT_UART_TX] = fsel.uart;
   assign slot_en[ppc_pkg::SLOT_UART_RX] = fsel.uart;
   assign slot_en[ppc_pkg::SLOT_RSPI_BASE+3:ppc_pkg::SLOT_RSPI_BASE] = {4{fsel.radio_spi}};
   assign slot_en[ppc_pkg::SLOT_GSPI_SCK] = fsel.general_spi;
   assign slot_en[ppc_pkg::SLOT_GSPI_MISO] = fsel.general_spi;
   assign slot_en[ppc_pkg::SLOT_GSPI_MOSI] = fsel.general_spi;
   // slave select only in 4-wire mode
   assign slot_en[ppc_pkg::SLOT_GSPI_NSS] = fsel.general_spi & nss_4wire;
   assign slot_en[ppc_pkg::SLOT_SMB_SDA] = fsel.smbus;
   assign slot_en[ppc_pkg::SLOT_SMB_SCL] = fsel.smbus;
   assign slot_en[ppc_pkg::SLOT_CMPA] = fsel.cmpa;
   assign slot_en[ppc_pkg::SLOT_CMPA_ASYNC] = fsel.cmpa_async;
   assign slot_en[ppc_pkg::SLOT_CMPB] = fsel.cmpb;
   assign slot_en[ppc_pkg::SLOT_CMPB_ASYNC] = fsel.cmpb_async;
   assign slot_en[ppc_pkg::SLOT_SYSCLK] = fsel.sysclk;
   for (genvar i = 0; i < ppc_pkg::PCA_MAX; i++) begin : g_pca
      assign slot_en[ppc_pkg::SLOT_PCA_BASE+i] = (i < PCA_CHANNELS) && (32'(fsel.pca_channels) > i);
   end
   assign slot_en[ppc_pkg::SLOT_PCA_ECI] = fsel.pca_eci;
   assign slot_en[ppc_pkg::SLOT_TIMER0] = fsel.timer0;
   assign slot_en[ppc_pkg::SLOT_TIMER1] = fsel.timer1;

   // Pin ownership
   logic [NP-1:0] taken;
   logic [NP-1:0] valid_nxt;
   logic [SW-1:0] own_nxt [NP];
   logic [NP-1:0] valid_r;
   logic [SW-1:0] own_r [NP];
   logic placed;

   always_comb begin
      taken = skip_vec;
      valid_nxt = '0;
      placed = 1'b0;
      for (int p = 0; p < NP; p++) begin
         own_nxt[p] = ppc_pkg::RST_OWNER;
      end
      if (crossbar_enable_bit) begin
         if (fsel.uart) begin
            taken[ppc_pkg::PIN_UART_TX] = 1'b1;
            taken[ppc_pkg::PIN_UART_RX] = 1'b1;
            valid_nxt[ppc_pkg::PIN_UART_TX] = 1'b1;
            valid_nxt[ppc_pkg::PIN_UART_RX] = 1'b1;
            own_nxt[ppc_pkg::PIN_UART_TX] = SW'(ppc_pkg::SLOT_UART_TX);
            own_nxt[ppc_pkg::PIN_UART_RX] = SW'(ppc_pkg::SLOT_UART_RX);
         end
         if (fsel.radio_spi) begin
            for (int k = 0; k < ppc_pkg::RSPI_PINS; k++) begin
               taken[ppc_pkg::PIN_RSPI_BASE+k] = 1'b1;
               valid_nxt[ppc_pkg::PIN_RSPI_BASE+k] = 1'b1;
               own_nxt[ppc_pkg::PIN_RSPI_BASE+k] = SW'(ppc_pkg::SLOT_RSPI_BASE + k);
            end
         end
         // lowest free pin per slot, priority order
         for (int s = ppc_pkg::SLOT_GSPI_SCK; s < NS; s++) begin
            placed = 1'b0;
            for (int p = 0; p < NP; p++) begin
               // skipped or taken pins passed over
               if (slot_en[s] && !placed && !taken[p]) begin
                  taken[p] = 1'b1;
                  valid_nxt[p] = 1'b1;
                  own_nxt[p] = SW'(s);
                  placed = 1'b1;
               end
            end
         end
      end
   end

   // Input synchroniser: pins 0..14 plus P2.7 at the top
   logic [NP:0] sync1_r;
   logic [NP:0] sync2_r;
   wire [NP-1:0] pin_sync = sync2_r[NP-1:0];

   // Pin drive values, taken from the new ownership
   logic [NP-1:0] val_nxt;
   logic [NP-1:0] drv_nxt;
   logic [NP-1:0] oe_nxt;
   logic [NS-1:0] pin_to_periph;
   wire [NP-1:0] bypass_pins = (NP'(fixed_sel.analog_ground_ref) << ppc_pkg::PIN_ANALOG_GROUND_REF)
                             | (NP'(fixed_sel.iref) << ppc_pkg::PIN_IREF)
                             | (NP'(fixed_sel.osc_in) << ppc_pkg::PIN_OSC_IN)
                             | (NP'(fixed_sel.osc_out) << ppc_pkg::PIN_OSC_OUT);

   always_comb begin
      pin_to_periph = '0;
      for (int p = 0; p < NP; p++) begin
         // unassigned digital pins act as GPIO
         val_nxt[p] = valid_nxt[p] ? periph_out[own_nxt[p]] : gpio_latch[p];
         drv_nxt[p] = valid_nxt[p] ? periph_drive[own_nxt[p]] : 1'b1;
         // SMBus pins open-drain, others per mode select
         oe_nxt[p] = crossbar_enable_bit & pin_digital[p] & ~bypass_pins[p] & drv_nxt[p]
                   & ((output_mode_select[p] & ~(valid_nxt[p] & fsel.smbus
                       & ((own_nxt[p] == SW'(ppc_pkg::SLOT_SMB_SDA))
                       | (own_nxt[p] == SW'(ppc_pkg::SLOT_SMB_SCL))))) | ~val_nxt[p]);
         if (valid_r[p] && pin_digital[p]) begin
            pin_to_periph[own_r[p]] = pin_sync[p];
         end
      end
   end

   // Event capture
   wire irq0_lvl = pin_digital[evt_cfg.irq0_pin] & (pin_sync[evt_cfg.irq0_pin] == evt_cfg.irq0_pol);
   wire irq1_lvl = pin_digital[evt_cfg.irq1_pin] & (pin_sync[evt_cfg.irq1_pin] == evt_cfg.irq1_pol);
   wire mismatch = |(match_mask & pin_digital & (pin_sync ^ match_value));
   logic irq0_prev_r;
   logic irq1_prev_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         // Idle pads sit at the pull-up level, so no false edge after reset
         sync1_r <= '1;
         sync2_r <= '1;
         valid_r <= ppc_pkg::RST_PINS;
         for (int p = 0; p < NP; p++) begin
            own_r[p] <= ppc_pkg::RST_OWNER;
         end
      end else begin
         sync1_r <= {p27_in, pin_in};
         sync2_r <= sync1_r;
         valid_r <= valid_nxt;
         own_r <= own_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pin_out <= ppc_pkg::RST_PINS;
         pin_oe <= ppc_pkg::RST_PINS;
         p27_out <= 1'b0;
         p27_oe <= 1'b0;
         analog_sw <= '0;
      end else begin
         pin_out <= val_nxt;
         pin_oe <= oe_nxt;
         p27_out <= p27_latch;
         p27_oe <= crossbar_enable_bit & (p27_push_pull | ~p27_latch);
         analog_sw <= fixed_sel;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         periph_in <= '0;
         pin_read <= ppc_pkg::RST_PINS;
         p27_read <= 1'b0;
         irq0_prev_r <= 1'b1;
         irq1_prev_r <= 1'b1;
         ext_irq0_evt <= 1'b0;
         ext_irq1_evt <= 1'b0;
         port_match <= 1'b0;
         match_wake <= 1'b0;
      end else begin
         periph_in <= pin_to_periph;
         pin_read <= pin_sync & pin_digital;
         p27_read <= sync2_r[NP];
         irq0_prev_r <= irq0_lvl;
         irq1_prev_r <= irq1_lvl;
         // edge events on digital pins, skip ignored
         ext_irq0_evt <= irq0_lvl & ~irq0_prev_r;
         ext_irq1_evt <= irq1_lvl & ~irq1_prev_r;
         port_match <= mismatch;
         match_wake <= mismatch & ~port_match;
      end
   end

   assign pin_assigned = valid_r;

   // Helper for slave select placement
   logic nss_placed;
   always_comb begin
      nss_placed = 1'b0;
      for (int p = 0; p < NP; p++) begin
         if (valid_r[p] && own_r[p] == SW'(ppc_pkg::SLOT_GSPI_NSS)) begin
            nss_placed = 1'b1;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_xbar_off_quiet: assert property (!crossbar_enable_bit |=> (pin_oe == '0) && !p27_oe)
      else $error("pin driver on while crossbar disabled");
   a_uart_fixed_pins: assert property (crossbar_enable_bit && fsel.uart |=>
      valid_r[ppc_pkg::PIN_UART_TX] && own_r[ppc_pkg::PIN_UART_RX] == SW'(ppc_pkg::SLOT_UART_RX))
      else $error("uart not on its fixed pins");
   a_radio_fixed_pins: assert property (crossbar_enable_bit && fsel.radio_spi |=>
      own_r[ppc_pkg::PIN_RSPI_BASE+3] == SW'(ppc_pkg::SLOT_RSPI_BASE + 3))
      else $error("radio spi not on its fixed pins");
   a_skip_pin_free: assert property (!fsel.uart && !fsel.radio_spi |=>
      (valid_r & $past(skip_vec)) == '0)
      else $error("skipped pin assigned");
   a_first_free_pin: assert property (crossbar_enable_bit && fsel.general_spi && !fsel.uart
      && !fsel.radio_spi && skip_vec == '0 |=> own_r[0] == SW'(ppc_pkg::SLOT_GSPI_SCK))
      else $error("general spi clock not on lowest pin");
   a_skip_passed_over: assert property (crossbar_enable_bit && fsel.general_spi && !fsel.uart
      && !fsel.radio_spi && skip_vec[1:0] == 2'h1 |=> own_r[1] == SW'(ppc_pkg::SLOT_GSPI_SCK) && !valid_r[0])
      else $error("skipped pin not passed over");
   a_nss_3wire_none: assert property (!nss_4wire |=> !nss_placed)
      else $error("slave select routed in 3-wire mode");
   a_smb_open_drain: assert property (crossbar_enable_bit && fsel.smbus && valid_nxt[0]
      && own_nxt[0] == SW'(ppc_pkg::SLOT_SMB_SDA) && periph_out[ppc_pkg::SLOT_SMB_SDA] |=> !pin_oe[0])
      else $error("smbus pin driven high");
   a_analog_ground_ref_bypass: assert property (fixed_sel.analog_ground_ref |=> analog_sw.analog_ground_ref && !pin_oe[ppc_pkg::PIN_ANALOG_GROUND_REF])
      else $error("analog ground pin not bypassed");
   a_osc_bypass: assert property (fixed_sel.osc_out |=> analog_sw.osc_out && !pin_oe[ppc_pkg::PIN_OSC_OUT])
      else $error("oscillator pin not bypassed");
   a_analog_no_evt: assert property (!pin_digital[evt_cfg.irq0_pin] |=> !ext_irq0_evt)
      else $error("event on analog pin");
   a_evt_one_pulse: assert property (ext_irq0_evt |=> !ext_irq0_evt)
      else $error("event longer than one cycle");
   a_p27_gpio: assert property (crossbar_enable_bit && p27_push_pull |=> p27_oe)
      else $error("P2.7 not driven as gpio");

   c_uart_and_radio: cover property (crossbar_enable_bit && fsel.uart && fsel.radio_spi ##1 valid_r[11]);
   c_nss_placed: cover property (nss_placed);
   c_evt_skipped_pin: cover property (ext_irq0_evt && skip_vec[evt_cfg.irq0_pin]);
   c_match_wake: cover property (match_wake);
endmodule

// ### ppc_pin_model.sv
// Package pin model: resolves each port pad from crossbar drive, external drive and pull-up, P2.7 from crossbar drive and pull-up only
`timescale 1ns/100ps
module ppc_pin_model (
   // Crossbar pin drivers
   input wire logic [ppc_pkg::NUM_PINS-1:0] pin_out,
   input wire logic [ppc_pkg::NUM_PINS-1:0] pin_oe,
   input wire logic p27_out,
   input wire logic p27_oe,
   // Board side drivers
   input wire logic [ppc_pkg::NUM_PINS-1:0] ext_en,
   input wire logic [ppc_pkg::NUM_PINS-1:0] ext_val,
   // Pad levels seen by the crossbar
   output logic [ppc_pkg::NUM_PINS-1:0] pin_in,
   output logic p27_in
);
   // Released pads fall back to the weak pull-up level
   always_comb begin
      for (int p = 0; p < ppc_pkg::NUM_PINS; p++) begin
         pin_in[p] = pin_oe[p] ? pin_out[p] : (ext_en[p] ? ext_val[p] : 1'b1);
      end
      p27_in = p27_oe ? p27_out : 1'b1;
   end
endmodule

// ### ppc_pkg.sv
// Constants and carrier types of the priority pin crossbar
package ppc_pkg;
   localparam int NUM_PINS = 15;
   localparam int PIN_W = 4;
   localparam int PORT0_W = 8;
   localparam int PORT1_W = 7;
   localparam int PCA_MAX = 6;
   localparam int NUM_SLOTS = 20 + PCA_MAX;
   localparam int SLOT_W = 5;
   // Fixed pin positions, pin index = 8 * port + bit
   localparam int PIN_ANALOG_GROUND_REF = 1;
   localparam int PIN_OSC_IN = 2;
   localparam int PIN_OSC_OUT = 3;
   localparam int PIN_UART_TX = 4;
   localparam int PIN_UART_RX = 5;
   localparam int PIN_IREF = 7;
   localparam int PIN_RSPI_BASE = 8;
   localparam int RSPI_PINS = 4;
   // Peripheral signal slots in priority order
   localparam int SLOT_UART_TX = 0;
   localparam int SLOT_UART_RX = 1;
   localparam int SLOT_RSPI_BASE = 2;
   localparam int SLOT_GSPI_SCK = 6;
   localparam int SLOT_GSPI_MISO = 7;
   localparam int SLOT_GSPI_MOSI = 8;
   localparam int SLOT_GSPI_NSS = 9;
   localparam int SLOT_SMB_SDA = 10;
   localparam int SLOT_SMB_SCL = 11;
   localparam int SLOT_CMPA = 12;
   localparam int SLOT_CMPA_ASYNC = 13;
   localparam int SLOT_CMPB = 14;
   localparam int SLOT_CMPB_ASYNC = 15;
   localparam int SLOT_SYSCLK = 16;
   localparam int SLOT_PCA_BASE = 17;
   localparam int SLOT_PCA_ECI = SLOT_PCA_BASE + PCA_MAX;
   localparam int SLOT_TIMER0 = SLOT_PCA_ECI + 1;
   localparam int SLOT_TIMER1 = SLOT_PCA_ECI + 2;
   // Slave select mode value that means 3-wire operation
   localparam logic [1:0] NSS_MODE_3WIRE = 2'h0;
   // Reset values
   localparam logic [SLOT_W-1:0] RST_OWNER = 5'h00;
   localparam logic [NUM_PINS-1:0] RST_PINS = 15'h0000;

   typedef struct packed {
      logic uart;
      logic radio_spi;
      logic general_spi;
      logic smbus;
      logic cmpa;
      logic cmpa_async;
      logic cmpb;
      logic cmpb_async;
      logic sysclk;
      logic [2:0] pca_channels;
      logic pca_eci;
      logic timer0;
      logic timer1;
   } ppc_fsel_s;

   typedef struct packed {
      logic analog_ground_ref;
      logic iref;
      logic osc_in;
      logic osc_out;
   } ppc_fixed_s;

   typedef struct packed {
      logic [2:0] irq0_pin;
      logic irq0_pol;
      logic [2:0] irq1_pin;
      logic irq1_pol;
   } ppc_evt_cfg_s;
endpackage

// ### priority_pin_crossbar_bench.sv
// Self-checking bench of the priority pin crossbar
`timescale 1ns/100ps
module priority_pin_crossbar_bench;
   localparam int PCA_N = 4;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   ppc_pkg::ppc_fsel_s fsel = '0;
   logic [1:0] ssm = 2'h0;
   logic [7:0] sk0 = 8'h00;
   logic [6:0] sk1 = 7'h00;
   ppc_pkg::ppc_fixed_s fx = '0;
   ppc_pkg::ppc_evt_cfg_s ec = '0;
   logic [14:0] dig = 15'h7fff, oms = 15'h7fff, gl = 15'h0000, mm = 15'h0000, mv = 15'h0000;
   logic [14:0] ext_en = 15'h0000, ext_val = 15'h0000;
   logic p27l = 1'b0, p27pp = 1'b0;
   logic [25:0] po = 26'h0000000, pd = 26'h3ffffff;
   logic [25:0] periph_in;
   logic [14:0] pin_in, pin_out, pin_oe, pin_read, pin_assigned;
   logic p27_in, p27_out, p27_oe, p27_read, irq0, irq1, port_match, match_wake;
   ppc_pkg::ppc_fixed_s analog_sw;
   int mismatches = 0;
   int cmp_count = 0;
   int own[15];

   ppc_crossbar #(.PCA_CHANNELS(PCA_N)) i_ppc_crossbar (.core_clk(core_clk), .rst_n(rst_n),
      .crossbar_enable_bit(en), .fsel(fsel), .slave_select_mode_bits(ssm), .port0_skip_vector(sk0),
      .port1_skip_vector(sk1), .fixed_sel(fx), .pin_digital(dig), .output_mode_select(oms),
      .gpio_latch(gl), .p27_latch(p27l), .p27_push_pull(p27pp), .evt_cfg(ec), .match_mask(mm),
      .match_value(mv), .periph_out(po), .periph_drive(pd), .periph_in(periph_in), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_read(pin_read), .p27_in(p27_in), .p27_out(p27_out),
      .p27_oe(p27_oe), .p27_read(p27_read), .analog_sw(analog_sw), .ext_irq0_evt(irq0),
      .ext_irq1_evt(irq1), .port_match(port_match), .match_wake(match_wake), .pin_assigned(pin_assigned));

   ppc_pin_model i_ppc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .p27_out(p27_out), .p27_oe(p27_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in), .p27_in(p27_in));

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Expected owner of every pin, built from the placement order
   task automatic build_map;
      logic [25:0] sel;
      logic [14:0] used;
      int n;
      sel = '0;
      used = {sk1, sk0};
      for (int p = 0; p < 15; p++) own[p] = -1;
      if (fsel.uart) begin
         own[4] = 0;
         own[5] = 1;
         used[5:4] = 2'h3;
      end
      for (int k = 0; k < 4; k++) if (fsel.radio_spi) begin
         own[8 + k] = 2 + k;
         used[8 + k] = 1'b1;
      end
      sel[8:6] = {3{fsel.general_spi}};
      sel[9] = fsel.general_spi && (ssm != ppc_pkg::NSS_MODE_3WIRE);
      sel[16:10] = {fsel.sysclk, fsel.cmpb_async, fsel.cmpb, fsel.cmpa_async, fsel.cmpa, {2{fsel.smbus}}};
      n = (fsel.pca_channels > PCA_N) ? PCA_N : fsel.pca_channels;
      for (int k = 0; k < n; k++) sel[17 + k] = 1'b1;
      sel[25:23] = {fsel.timer1, fsel.timer0, fsel.pca_eci};
      for (int s = 6; s < 26; s++) if (sel[s]) begin
         for (int p = 0; p < 15; p++) if (!used[p]) begin
            own[p] = s;
            used[p] = 1'b1;
            break;
         end
      end
   endtask

   // Placement of every slot, observed one slot at a time
   task automatic check_map;
      logic [14:0] ea, eo;
      build_map();
      ea = '0;
      for (int p = 0; p < 15; p++) ea[p] = (own[p] >= 0);
      tick(2);
      chk("pin_assigned", ea, pin_assigned);
      for (int s = 0; s < 26; s++) begin
         po = 26'h1 << s;
         eo = '0;
         for (int p = 0; p < 15; p++) eo[p] = (own[p] == s);
         tick(2);
         chk("pin_out", eo, pin_out);
      end
      po = '0;
   endtask

   task automatic test_map;
      en = 1'b1;
      fsel = '0;
      fsel.general_spi = 1'b1;
      check_map();
      fsel = '0;
      {fsel.uart, fsel.radio_spi, fsel.general_spi, fsel.smbus, fsel.cmpa, fsel.sysclk} = 6'h3f;
      fsel.pca_channels = 3'h5;
      fsel.timer1 = 1'b1;
      ssm = 2'h1;
      sk0 = 8'h0c;
      check_map();
      fsel = '0;
      {fsel.cmpb, fsel.cmpb_async, fsel.pca_eci, fsel.timer0, fsel.cmpa_async} = 5'h1f;
      fsel.pca_channels = 3'h6;
      sk0 = 8'h81;
      sk1 = 7'h10;
      check_map();
      sk0 = 8'h00;
      sk1 = 7'h00;
   endtask

   task automatic test_disabled;
      en = 1'b0;
      fsel = '0;
      fsel.general_spi = 1'b1;
      p27pp = 1'b1;
      tick(2);
      chk("pin_oe", 15'h0000, pin_oe);
      chk("p27_oe", 1'b0, p27_oe);
   endtask

   task automatic test_fixed_smbus;
      en = 1'b1;
      fsel = '0;
      fsel.smbus = 1'b1;
      tick(2);
      chk("pin_oe sda scl low", 2'h3, pin_oe[1:0]);
      po[11:10] = 2'h3;
      tick(2);
      chk("pin_oe sda scl high", 2'h0, pin_oe[1:0]);
      fsel.general_spi = 1'b1;
      fsel.smbus = 1'b0;
      po = '0;
      fx = 4'hf;
      tick(2);
      chk("analog_sw", 4'hf, analog_sw);
      chk("pin_oe bypass", 15'h0000, pin_oe & 15'h008e);
      fx = '0;
   endtask

   task automatic test_gpio;
      fsel = '0;
      sk0 = 8'h01;
      for (int k = 0; k < 4; k++) begin
         {p27pp, p27l} = k[1:0];
         gl[0] = k[0];
         tick(2);
         chk("p27_oe", 1'(p27pp | ~p27l), p27_oe);
         chk("p27_out", p27l, p27_out);
         chk("pin_out gpio", k[0], pin_out[0]);
      end
      tick(2);
      chk("p27_read", 1'b1, p27_read);
      chk("pin_read gpio", 1'b1, pin_read[0]);
      sk0 = 8'h00;
   endtask

   task automatic watch(input int w, input int e, input string nm);
      int c;
      c = 0;
      for (int k = 0; k < 12; k++) begin
         tick(1);
         if (((w == 0) ? irq0 : (w == 1) ? match_wake : irq1) === 1'b1) c++;
      end
      chk(nm, e, c);
   endtask

   // events on skipped, claimed and analog pins
   task automatic test_events;
      oms = '0;
      gl = 15'h7fff;
      pd = '0;
      ec.irq0_pin = 3'h3;
      ec.irq0_pol = 1'b1;
      ec.irq1_pin = 3'h3;
      ec.irq1_pol = 1'b0;
      ext_en = 15'h0208;
      ext_val = '0;
      sk0 = 8'h08;
      tick(4);
      ext_val[3] = 1'b1;
      watch(0, 1, "irq0 skipped pin");
      ext_val[3] = 1'b0;
      watch(2, 1, "irq1 falling pin");
      sk0 = 8'h00;
      fsel.general_spi = 1'b1;
      ssm = 2'h1;
      tick(4);
      ext_val[3] = 1'b1;
      watch(0, 1, "irq0 crossbar pin");
      chk("periph_in nss", 1'b1, periph_in[ppc_pkg::SLOT_GSPI_NSS]);
      ext_val[3] = 1'b0;
      tick(4);
      dig[3] = 1'b0;
      ext_val[3] = 1'b1;
      watch(0, 0, "irq0 analog pin");
      chk("pin_read analog", 1'b0, pin_read[3]);
      dig[3] = 1'b1;
      mm = 15'h0200;
      ext_val[9] = 1'b1;
      watch(1, 1, "match_wake");
      chk("port_match", 1'b1, port_match);
   endtask

   initial begin
      tick(20);
      rst_n = 1'b1;
      tick(1);
      chk("pin_oe reset", 15'h0000, pin_oe);
      chk("pin_assigned reset", 15'h0000, pin_assigned);
      test_disabled();
      test_map();
      test_fixed_smbus();
      test_gpio();
      test_events();
      print_verdict();
   end
endmodule
